// ### shared/ogb_defs.svh
`ifndef OGB_DEFS_SVH
`define OGB_DEFS_SVH
// ----------------------------------------
// Register map (word offsets as byte addresses)
// ----------------------------------------
`define OGB_ADDR_CONFIG     6'h00
`define OGB_ADDR_OFFSET_A   6'h04
`define OGB_ADDR_OFFSET_B   6'h08
`define OGB_ADDR_GPIO       6'h0c
`define OGB_ADDR_IRQ_STATUS 6'h10
`define OGB_ADDR_IRQ_MASK   6'h14
// ----------------------------------------
// Config fields
// ----------------------------------------
`define OGB_CFG_CORR_EN     0
`define OGB_CFG_GAIN        1
`define OGB_CFG_BUSY_FLAG   2
`define OGB_CFG_SINGLE      3
// ----------------------------------------
// Interrupt status fields
// ----------------------------------------
`define OGB_IRQ_BUSY_START  0
`define OGB_IRQ_BUSY_DONE   1
`define OGB_IRQ_GAIN_CHG    2
`define OGB_IRQ_W           3
// ----------------------------------------
// Default offset codes, straight binary
// ----------------------------------------
`define OGB_OFS_G6_SB       12'h99a
`define OGB_OFS_G4_SB       12'haab
// Twos complement form flips the top bit
`define OGB_OFS_TC_FLIP     12'h800
`define OGB_CODE_W          12
`endif

// ### shared/ogb_pkg.sv
package ogb_pkg;
	typedef struct packed {
		logic [5:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} ogb_bus_req_s;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} ogb_bus_rsp_s;

	typedef enum logic [1:0] {
		OGB_IDLE = 2'b00,
		OGB_RESP = 2'b01
	} ogb_bus_e;

	typedef struct packed {
		ogb_bus_e    bus;
		logic [31:0] readdata;
		logic        waitrequest;
		logic        corr_en;
		logic        gain_six;
		logic [11:0] ofs_a;
		logic [11:0] ofs_b;
		logic        gpio_bit;
		logic [2:0]  irq_status;
		logic [2:0]  irq_mask;
		logic        busy_flag;
		logic        busy_oe;
		logic        gpio_oe;
		logic        ofs_power;
		logic [11:0] code_a;
		logic [11:0] code_b;
		logic        irq;
	} ogb_state_s;
endpackage

// ### logic/ogb_offset_gpio_busy.sv
`timescale 1ns/100ps
`include "ogb_defs.svh"
// Functional notes
// - Two 12-bit offset codes, groups A, B
// - Larger code shifts group outputs negative
// - Reset loads format and range default
// - Gain change reloads both offset defaults
// - Defaults trimmed per gain six four
// - Single supply keeps offset converters off
// - Pin released at one, low at zero
// - Reading pin bit returns pin level
// - Reset sets pin bit to one
// - Engine running sets flag, pulls busy low
// - Engine finished releases busy line
// - Shared busy low until all finish
// - Correction enable bit, default off
// - Engine disabled forces flag zero, released
module ogb_offset_gpio_busy
(
	input  wire logic                clk,          // 50 MHz clock
	input  wire logic                rst,          // Sync reset, high
	input  wire logic                ce,           // Clock enable
	input  wire ogb_pkg::ogb_bus_req_s bus_req,    // Avalon-MM request
	output      ogb_pkg::ogb_bus_rsp_s bus_rsp,    // Avalon-MM response
	input  wire logic                twos_comp,    // Data format select
	input  wire logic                single_supply, // Supply mode
	input  wire logic                engine_run,   // Correction engine active
	input  wire logic                gpio_in,      // GPIO pin level
	output      logic                gpio_out,     // GPIO drive value
	output      logic                gpio_oe,      // GPIO drive enable
	input  wire logic                busy_in,      // Shared busy line level
	output      logic                busy_out,     // Busy drive value
	output      logic                busy_oe,      // Busy drive enable
	output      logic [11:0]         ofs_code_a,   // Group A offset code
	output      logic [11:0]         ofs_code_b,   // Group B offset code
	output      logic                ofs_power,    // Offset converters on
	output      logic                irq           // Level interrupt
);
	import ogb_pkg::*;

	ogb_state_s st;
	ogb_state_s next_st;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Default code for a gain, in the active data format
	function automatic logic [11:0] ofs_default(input logic six, input logic tc);
		logic [11:0] c;
		c = six ? `OGB_OFS_G6_SB : `OGB_OFS_G4_SB;
		ofs_default = tc ? (c ^ `OGB_OFS_TC_FLIP) : c;
	endfunction

	function automatic logic [31:0] zext12(input logic [11:0] v);
		zext12 = {20'h0, v};
	endfunction

	// Byte address cut to its word, low bits ignored
	function automatic logic [5:0] word_addr(input logic [5:0] a);
		word_addr = {a[5:2], 2'b00};
	endfunction

	logic       acc_wr;
	logic       acc_rd;
	logic       busy_ev_start;
	logic       busy_ev_done;
	logic       gain_ev;
	logic       new_gain;
	logic [2:0] ev_set;

	always_comb
	begin
		next_st = st;
		acc_wr = 1'b0;
		acc_rd = 1'b0;
		new_gain = st.gain_six;
		gain_ev = 1'b0;
		// ----------------------------------------
		// Bus slave: one wait cycle, answer on second
		// ----------------------------------------
		case (st.bus)
			OGB_IDLE:
			begin
				next_st.waitrequest = 1'b1;
				if (bus_req.read || bus_req.write)
				begin
					next_st.bus = OGB_RESP;
					next_st.waitrequest = 1'b0;
					// Load read data now so it stands while waitrequest is low
					acc_rd = bus_req.read;
				end
			end
			OGB_RESP:
			begin
				acc_wr = bus_req.write;
				next_st.bus = OGB_IDLE;
				next_st.waitrequest = 1'b1;
			end
			default:
			begin
				next_st.bus = OGB_IDLE;
				next_st.waitrequest = 1'b1;
			end
		endcase

		if (acc_rd)
		begin
			case (word_addr(bus_req.address))
				`OGB_ADDR_CONFIG:
					next_st.readdata = {28'h0, st.ofs_power ? 1'b0 : 1'b1, st.busy_flag,
						st.gain_six, st.corr_en};
				`OGB_ADDR_OFFSET_A:   next_st.readdata = zext12(st.ofs_a);
				`OGB_ADDR_OFFSET_B:   next_st.readdata = zext12(st.ofs_b);
				`OGB_ADDR_GPIO:       next_st.readdata = {31'h0, gpio_in};
				`OGB_ADDR_IRQ_STATUS: next_st.readdata = {29'h0, st.irq_status};
				`OGB_ADDR_IRQ_MASK:   next_st.readdata = {29'h0, st.irq_mask};
				default:              next_st.readdata = 32'h0;
			endcase
		end

		if (acc_wr)
		begin
			case (word_addr(bus_req.address))
				`OGB_ADDR_CONFIG:
				begin
					next_st.corr_en = bus_req.writedata[`OGB_CFG_CORR_EN];
					new_gain = bus_req.writedata[`OGB_CFG_GAIN];
				end
				`OGB_ADDR_OFFSET_A:   next_st.ofs_a = bus_req.writedata[11:0];
				`OGB_ADDR_OFFSET_B:   next_st.ofs_b = bus_req.writedata[11:0];
				`OGB_ADDR_GPIO:       next_st.gpio_bit = bus_req.writedata[0];
				`OGB_ADDR_IRQ_MASK:   next_st.irq_mask = bus_req.writedata[2:0];
				default:
				begin
				end
			endcase
		end

		// Gain change overrides any offset write in the same access
		gain_ev = (new_gain != st.gain_six);
		next_st.gain_six = new_gain;
		if (gain_ev)
		begin
			next_st.ofs_a = ofs_default(new_gain, twos_comp);
			next_st.ofs_b = ofs_default(new_gain, twos_comp);
		end

		// ----------------------------------------
		// Busy flag and open-drain line
		// ----------------------------------------
		next_st.busy_flag = st.corr_en && engine_run;
		next_st.busy_oe = next_st.busy_flag;
		busy_ev_start = next_st.busy_flag && !st.busy_flag;
		busy_ev_done = !next_st.busy_flag && st.busy_flag;

		next_st.gpio_oe = !next_st.gpio_bit;
		next_st.ofs_power = !single_supply;

		// Set wins over a write-one clear
		ev_set = {gain_ev, busy_ev_done, busy_ev_start};
		if (acc_wr && (word_addr(bus_req.address) == `OGB_ADDR_IRQ_STATUS))
			next_st.irq_status = st.irq_status & ~bus_req.writedata[2:0];
		next_st.irq_status = next_st.irq_status | ev_set;
		next_st.irq = |(next_st.irq_status & next_st.irq_mask);

		if (rst)
		begin
			next_st = '0;
			next_st.bus = OGB_IDLE;
			next_st.waitrequest = 1'b1;
			next_st.gain_six = 1'b1;
			next_st.ofs_a = ofs_default(1'b1, twos_comp);
			next_st.ofs_b = ofs_default(1'b1, twos_comp);
			next_st.gpio_bit = 1'b1;
			next_st.ofs_power = !single_supply;
		end

		// Converters off drive code zero to avoid stray current
		next_st.code_a = next_st.ofs_power ? next_st.ofs_a : 12'h000;
		next_st.code_b = next_st.ofs_power ? next_st.ofs_b : 12'h000;
	end

	always_ff @(posedge clk)
	begin
		if (ce || rst)
			st <= next_st;
	end

	// ----------------------------------------
	// Outputs straight from state, pin drive values tied to zero
	// ----------------------------------------
	assign bus_rsp.readdata = st.readdata;
	assign bus_rsp.waitrequest = st.waitrequest;
	assign gpio_out = 1'b0;
	assign gpio_oe = st.gpio_oe;
	assign busy_out = 1'b0;
	assign busy_oe = st.busy_oe;
	assign ofs_code_a = st.code_a;
	assign ofs_code_b = st.code_b;
	assign ofs_power = st.ofs_power;
	assign irq = st.irq;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_gain_write;
		ce && acc_wr && (bus_req.address[5:2] == 4'h0)
			&& (bus_req.writedata[`OGB_CFG_GAIN] != st.gain_six);
	endsequence

	a_gain_reload: assert property (@(posedge clk) disable iff (rst)
		s_gain_write |=> (st.ofs_a == ofs_default(st.gain_six, $past(twos_comp))))
		else $error("offset not reloaded on gain change");
	a_gpio_drive: assert property (@(posedge clk) disable iff (rst)
		ce |=> (gpio_oe == !st.gpio_bit))
		else $error("gpio drive mismatch");
	a_gpio_reset: assert property (@(posedge clk) rst |=> (st.gpio_bit && !gpio_oe))
		else $error("gpio not released after reset");
	a_busy_pull: assert property (@(posedge clk) disable iff (rst)
		(ce && st.corr_en && engine_run) |=> (busy_oe && st.busy_flag))
		else $error("busy not pulled");
	a_busy_off: assert property (@(posedge clk) disable iff (rst)
		(ce && !st.corr_en) |=> !busy_oe)
		else $error("busy driven while engine off");
	a_busy_release: assert property (@(posedge clk) disable iff (rst)
		(ce && !engine_run) |=> !busy_oe)
		else $error("busy held after finish");
	a_reset_default: assert property (@(posedge clk) rst |=>
		(st.ofs_a == ofs_default(1'b1, $past(twos_comp))) && (st.ofs_b == st.ofs_a))
		else $error("wrong reset offset");
	a_single_off: assert property (@(posedge clk) disable iff (rst)
		(ce && single_supply) |=> (!ofs_power && ofs_code_a == 12'h000))
		else $error("offset on in single supply");
	a_cfg_enable: assert property (@(posedge clk) disable iff (rst)
		(ce && acc_wr && bus_req.address[5:2] == 4'h0) |=>
			(st.corr_en == $past(bus_req.writedata[0])))
		else $error("enable bit not stored");
	a_ofs_write: assert property (@(posedge clk) disable iff (rst)
		(ce && acc_wr && bus_req.address[5:2] == 4'h1) |=>
			(st.ofs_a == $past(bus_req.writedata[11:0])))
		else $error("offset A not written");
	a_ofs_b_write: assert property (@(posedge clk) disable iff (rst)
		(ce && acc_wr && bus_req.address[5:2] == 4'h2) |=>
			(st.ofs_b == $past(bus_req.writedata[11:0])))
		else $error("offset B not written");
	a_gpio_write: assert property (@(posedge clk) disable iff (rst)
		(ce && acc_wr && bus_req.address[5:2] == 4'h3) |=>
			(st.gpio_bit == $past(bus_req.writedata[0])))
		else $error("gpio bit not written");
	a_gpio_read: assert property (@(posedge clk) disable iff (rst)
		(ce && acc_rd && bus_req.address[5:2] == 4'h3) |=>
			(bus_rsp.readdata == {31'h0, $past(gpio_in)}))
		else $error("gpio read not pin level");
	a_code_follow: assert property (@(posedge clk) disable iff (rst)
		(ce && !single_supply) |=>
			(ofs_code_a == st.ofs_a) && (ofs_code_b == st.ofs_b))
		else $error("converter code differs from register");

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	// One wait state: answer a cycle after the take, then back to waiting
	sequence s_bus_take;
		ce && (st.bus == OGB_IDLE) && (bus_req.read || bus_req.write);
	endsequence

	sequence s_bus_answer;
		ce && (st.bus == OGB_RESP);
	endsequence

	a_wait_one: assert property (@(posedge clk) disable iff (rst)
		s_bus_take |=> !bus_rsp.waitrequest)
		else $error("request not answered after one wait");
	a_wait_back: assert property (@(posedge clk) disable iff (rst)
		s_bus_answer |=> bus_rsp.waitrequest)
		else $error("waitrequest low for more than a cycle");
	a_read_stands: assert property (@(posedge clk) disable iff (rst)
		s_bus_take ##1 s_bus_answer |=> $stable(bus_rsp.readdata))
		else $error("read data moved after the answer");
	a_ce_freeze: assert property (@(posedge clk) disable iff (rst)
		!ce |=> $stable(st))
		else $error("state moved while clock enable low");

	// ----------------------------------------
	// Event flags
	// ----------------------------------------
	sequence s_busy_rise;
		ce && !st.busy_flag && st.corr_en && engine_run;
	endsequence

	// Disable write, then one enabled edge to clear the flag
	sequence s_cfg_off;
		ce && acc_wr && (bus_req.address[5:2] == 4'h0)
			&& !bus_req.writedata[`OGB_CFG_CORR_EN];
	endsequence

	a_busy_event: assert property (@(posedge clk) disable iff (rst)
		s_busy_rise |=> st.irq_status[`OGB_IRQ_BUSY_START])
		else $error("busy start not latched");
	a_gain_event: assert property (@(posedge clk) disable iff (rst)
		s_gain_write |=> st.irq_status[`OGB_IRQ_GAIN_CHG])
		else $error("gain change not latched");
	a_busy_stop: assert property (@(posedge clk) disable iff (rst)
		s_cfg_off ##1 ce |=> (!st.busy_flag && !busy_oe))
		else $error("busy held after engine disabled");
endmodule // ogb_offset_gpio_busy

// ### testbench/ogb_pin_env.sv
`timescale 1ns/100ps
// ----------------------------------------
// Pins outside the block: pull-ups and a second busy driver
// ----------------------------------------
module ogb_pin_env
(
	input  wire logic gpio_oe,    // Block pulls pin low
	input  wire logic busy_oe,    // Block pulls busy low
	input  wire logic ext_low,    // Outside source pulls pin low
	input  wire logic other_busy, // Second device still busy
	output      logic gpio_pin,   // Resolved pin level
	output      logic busy_pin    // Resolved shared busy line
);
	assign gpio_pin = !(gpio_oe || ext_low);
	// Wired low: any device still busy holds the line
	assign busy_pin = !(busy_oe || other_busy);
endmodule // ogb_pin_env

// ### testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import ogb_pkg::*;
	logic clk = 0, rst = 1, ce = 1, twos_comp = 0, single_supply = 0;
	logic engine_run = 0, ext_low = 0, other_busy = 0;
	ogb_bus_req_s bus_req = '0;
	ogb_bus_rsp_s bus_rsp;
	logic gpio_in, gpio_out, gpio_oe, busy_in, busy_out, busy_oe, ofs_power, irq;
	logic [11:0] ofs_code_a, ofs_code_b, ra, rb;
	logic [31:0] q[$];
	int failures = 0, n_checks = 0;
	always #10 clk = ~clk;
	ogb_offset_gpio_busy ogb_offset_gpio_busy_i(.clk(clk), .rst(rst), .ce(ce),
		.bus_req(bus_req), .bus_rsp(bus_rsp), .twos_comp(twos_comp),
		.single_supply(single_supply), .engine_run(engine_run), .gpio_in(gpio_in),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .busy_in(busy_in), .busy_out(busy_out),
		.busy_oe(busy_oe), .ofs_code_a(ofs_code_a), .ofs_code_b(ofs_code_b),
		.ofs_power(ofs_power), .irq(irq));
	ogb_pin_env ogb_pin_env_i(.gpio_oe(gpio_oe), .busy_oe(busy_oe), .ext_low(ext_low),
		.other_busy(other_busy), .gpio_pin(gpio_in), .busy_pin(busy_in));
	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task give_verdict;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// Read data taken at the edge that sees waitrequest low
	always @(posedge clk)
		if (bus_req.read && bus_rsp.waitrequest === 1'b0)
			chk("readdata", q.size() ? q.pop_front() : 32'hx, bus_rsp.readdata);
	// ----------------------------------------
	// Bus master
	// ----------------------------------------
	task acc(input logic w, input logic [5:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		bus_req <= '{a, ~w, w, d};
		for (i = 0; i < 20; i++)
		begin
			@(posedge clk);
			if (bus_rsp.waitrequest === 1'b0)
				break;
		end
		bus_req <= '0;
		if (i == 20)
		begin
			failures++;
			give_verdict;
		end
	endtask
	task wr(input logic [5:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask
	task rd(input logic [5:0] a, input logic [31:0] e);
		q.push_back(e);
		acc(1'b0, a, 32'h0);
	endtask
	// Outputs looked at once the edge's updates have landed
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task do_rst;
		@(posedge clk) rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		ra = 12'($urandom(24));
		ra = 12'($urandom);
		rb = 12'($urandom);
		do_rst;
		rd(6'h00, 32'h2);
		rd(6'h04, 32'h99a);
		rd(6'h08, 32'h99a);
		rd(6'h0c, 32'h1);
		rd(6'h18, 32'h0);
		chk("ofs_code_a", 32'h99a, ofs_code_a);
		chk("gpio_oe", 32'h0, gpio_oe);
		wr(6'h04, ra);
		wr(6'h08, rb);
		rd(6'h04, ra);
		rd(6'h08, rb);
		cyc(1);
		chk("ofs_code_b", rb, ofs_code_b);
		@(posedge clk) engine_run <= 1'b1;
		cyc(3);
		chk("busy_oe", 32'h0, busy_oe);
		rd(6'h00, 32'h2);
		wr(6'h00, 32'h3);
		cyc(3);
		chk("busy_oe", 32'h1, busy_oe);
		rd(6'h00, 32'h7);
		chk("irq", 32'h0, irq);
		@(posedge clk) engine_run <= 1'b0;
		other_busy <= 1'b1;
		cyc(3);
		chk("busy_oe", 32'h0, busy_oe);
		chk("busy_line", 32'h0, busy_in);
		rd(6'h00, 32'h3);
		wr(6'h14, 32'h7);
		cyc(2);
		chk("irq", 32'h1, irq);
		rd(6'h10, 32'h3);
		wr(6'h10, 32'h7);
		wr(6'h14, 32'h4);
		rd(6'h10, 32'h0);
		chk("irq", 32'h0, irq);
		@(posedge clk) other_busy <= 1'b0;
		cyc(1);
		chk("busy_line", 32'h1, busy_in);
		wr(6'h00, 32'h1);
		rd(6'h04, 32'haab);
		rd(6'h08, 32'haab);
		rd(6'h10, 32'h4);
		chk("irq", 32'h1, irq);
		wr(6'h0c, 32'h0);
		cyc(2);
		chk("gpio_oe", 32'h1, gpio_oe);
		rd(6'h0c, 32'h0);
		wr(6'h0c, 32'h1);
		@(posedge clk) ext_low <= 1'b1;
		cyc(2);
		chk("gpio_oe", 32'h0, gpio_oe);
		rd(6'h0c, 32'h0);
		@(posedge clk) ext_low <= 1'b0;
		rd(6'h0c, 32'h1);
		@(posedge clk) ce <= 1'b0;
		engine_run <= 1'b1;
		cyc(3);
		chk("busy_oe", 32'h0, busy_oe);
		@(posedge clk) ce <= 1'b1;
		cyc(2);
		chk("busy_oe", 32'h1, busy_oe);
		wr(6'h00, 32'h0);
		cyc(2);
		chk("busy_oe", 32'h0, busy_oe);
		rd(6'h00, 32'h0);
		@(posedge clk) engine_run <= 1'b0;
		@(posedge clk) twos_comp <= 1'b1;
		do_rst;
		rd(6'h04, 32'h19a);
		@(posedge clk) single_supply <= 1'b1;
		cyc(2);
		chk("ofs_power", 32'h0, ofs_power);
		chk("ofs_code_a", 32'h0, ofs_code_a);
		rd(6'h00, 32'ha);
		cyc(2);
		chk("pending", 32'h0, q.size());
		give_verdict;
	end
endmodule // tb_top
